// >>> rtl/contact_input_reference_modifier.sv
// Contact-input reference modifier: trim, sample-hold, source select, jog.
// Assumes same-clock analog and option-card values; pins asynchronous.
// Contract
// [R01] Trim increase and decrease functions selectable on any contact input.
// [R02] Trim level: percent of max frequency, 0..100, default 10, run-frozen.
// [R03] Increase alone adds trim, decrease alone subtracts, else unchanged.
// [R04] Trim acts only when reference is above zero and analog-sourced.
// [R05] A trimmed reference below zero is clamped to zero.
// [R06] Only one of trim increase/decrease assigned raises selection error.
// [R07] Sample-hold captures the analog reference 100 ms after turn-on.
// [R08] Sample-hold with ramp hold, up/down or trim raises selection error.
// [R09] Controller holds sample input 100 ms; shorter pulses hold nothing.
// [R10] Held reference is volatile and lost at power-off.
// [R11] Option/drive selection switches sources only while drive is stopped.
// [R12] Selection off uses terminals, on uses the option card for both.
// [R13] Configurer sets reference and run sources to terminal first.
// [R14] Forward and reverse jog run at jog frequency without run command.
// [R15] Jog frequency 0.00..400.00 Hz, default 6.00, changeable running.
// [R16] In second open-loop vector mode jog limited to 66.0, never above max.
// [R17] Active jog overrides every other reference source.
// [R18] Both jogs on for 500 ms stops the motor by configured stop method.
// [R19] Delays counted on the core clock, restarting when the condition ends.
`timescale 1ns/100ps
`default_nettype none
module contact_input_reference_modifier #(
  parameter int unsigned SAMPLE_DELAY_CYCLES = cirm_pkg::SAMPLE_DELAY_CYCLES,
  parameter int unsigned CONFLICT_CYCLES = cirm_pkg::CONFLICT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Contact pins and their function selections
  input wire logic [cirm_pkg::NUM_INPUTS-1:0] contact_pin_i,
  input wire logic [cirm_pkg::NUM_INPUTS-1:0][cirm_pkg::CODE_W-1:0]
    input_function_select_i,
  // Terminal run pins
  input wire logic terminal_run_pin_i,
  input wire logic terminal_reverse_pin_i,
  // Drive settings
  input wire logic [cirm_pkg::PCT_W-1:0] trim_level_setting_i,
  input wire logic [cirm_pkg::FREQ_W-1:0] jog_frequency_setting_i,
  input wire logic [cirm_pkg::FREQ_W-1:0] max_output_frequency_setting_i,
  input wire logic [cirm_pkg::SRC_W-1:0] reference_source_select_i,
  input wire logic [cirm_pkg::SRC_W-1:0] run_source_select_i,
  input wire logic [cirm_pkg::STOP_W-1:0] stop_method_select_i,
  input wire logic [cirm_pkg::CTRL_W-1:0] control_method_i,
  // Drive state and references
  input wire logic drive_running_i,
  input wire logic [cirm_pkg::FREQ_W-1:0] analog_reference_i,
  // Communications option card
  input wire logic [cirm_pkg::FREQ_W-1:0] option_reference_i,
  input wire logic option_run_i,
  input wire logic option_reverse_i,
  // Resulting command
  output logic [cirm_pkg::FREQ_W-1:0] frequency_reference_o,
  output logic run_command_o,
  output logic run_reverse_o,
  output logic jog_active_o,
  output logic option_selected_o,
  output logic hold_valid_o,
  output logic stop_request_o,
  output logic [cirm_pkg::STOP_W-1:0] stop_method_o,
  output logic invalid_input_selection_error_o
);
  func_flags_if #(.NUM_FUNCS(cirm_pkg::NUM_FUNCS)) flags_bus ();

  logic [1:0] run_meta;
  logic [1:0] run_sync;
  logic [cirm_pkg::PCT_W-1:0] trim_level;
  logic [cirm_pkg::FREQ_W-1:0] held_ref;
  logic sample_fire;
  logic conflict_expired;
  logic conflict_latched;
  logic [cirm_pkg::NUM_FUNCS-1:0] asg;
  logic [cirm_pkg::NUM_FUNCS-1:0] act;
  logic [cirm_pkg::FREQ_W-1:0] base_ref;
  logic from_analog;
  logic trim_en;
  logic [cirm_pkg::PROD_W-1:0] trim_prod;
  logic [cirm_pkg::FREQ_W-1:0] trim_amt;
  logic [cirm_pkg::FREQ_W:0] trim_sum;
  logic [cirm_pkg::FREQ_W-1:0] trimmed;
  logic [cirm_pkg::FREQ_W-1:0] jog_cap;
  logic [cirm_pkg::FREQ_W-1:0] jog_lim;
  logic fwd_jog;
  logic rev_jog;
  logic jog_any;
  logic both_jog;
  logic next_error;
  logic [cirm_pkg::FREQ_W-1:0] next_freq;
  logic next_run;
  logic next_reverse;

  assign asg = flags_bus.assigned;
  assign act = flags_bus.active;

  // ==========================================================
  // Pin decode and qualification timers
  input_decode u_decode (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .contact_pin_i(contact_pin_i),
    .function_select_i(input_function_select_i),
    .flags(flags_bus.source)
  );

  hold_timer #(.CYCLES(SAMPLE_DELAY_CYCLES)) u_sample_timer (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .cond_i(act[cirm_pkg::FN_SAMPLE_HOLD]),
    .expired_o(),
    .fire_o(sample_fire)
  );

  hold_timer #(.CYCLES(CONFLICT_CYCLES)) u_conflict_timer (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .cond_i(both_jog),
    .expired_o(conflict_expired),
    .fire_o()
  );

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      run_meta <= '0;
      run_sync <= '0;
    end else begin
      run_meta <= {terminal_reverse_pin_i, terminal_run_pin_i};
      run_sync <= run_meta;
    end
  end

  // ==========================================================
  // Trim level latched only while stopped
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      trim_level <= cirm_pkg::TRIM_PCT_DEFAULT; // [R02]
    end else if (!drive_running_i) begin
      trim_level <= (trim_level_setting_i > cirm_pkg::TRIM_PCT_MAX) ?
        cirm_pkg::TRIM_PCT_MAX : trim_level_setting_i; // [R02]
    end
  end

  // ==========================================================
  // Sample-hold capture; cleared only by reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      held_ref <= '0; // [R10]
      hold_valid_o <= 1'b0; // [R10]
    end else if (sample_fire) begin
      held_ref <= analog_reference_i; // [R07] [R09]
      hold_valid_o <= 1'b1;
    end
  end

  // ==========================================================
  // Source selection, frozen while running
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      option_selected_o <= 1'b0;
    end else if (!drive_running_i) begin
      option_selected_o <= act[cirm_pkg::FN_OPT_SEL]; // [R11]
    end
  end

  // ==========================================================
  // Reference arithmetic
  assign from_analog = !option_selected_o &&
    reference_source_select_i == cirm_pkg::REF_SRC_TERMINAL; // [R13]
  assign base_ref = option_selected_o ? option_reference_i :
    (hold_valid_o ? held_ref : analog_reference_i); // [R12] [R07]
  assign trim_en = asg[cirm_pkg::FN_TRIM_UP] && asg[cirm_pkg::FN_TRIM_DN] &&
    from_analog && base_ref != '0; // [R04]
  assign trim_prod = max_output_frequency_setting_i * trim_level;
  assign trim_amt = cirm_pkg::FREQ_W'(trim_prod / cirm_pkg::PCT_DIVISOR);
  assign trim_sum = {1'b0, base_ref} + {1'b0, trim_amt};

  always_comb begin
    trimmed = base_ref; // [R03]
    if (trim_en && act[cirm_pkg::FN_TRIM_UP] &&
        !act[cirm_pkg::FN_TRIM_DN]) begin
      trimmed = (trim_sum > {1'b0, max_output_frequency_setting_i}) ?
        max_output_frequency_setting_i :
        trim_sum[cirm_pkg::FREQ_W-1:0]; // [R03]
    end else if (trim_en && act[cirm_pkg::FN_TRIM_DN] &&
                 !act[cirm_pkg::FN_TRIM_UP]) begin
      trimmed = (base_ref < trim_amt) ? '0 : base_ref - trim_amt; // [R05]
    end
  end

  // ==========================================================
  // Jog limits and priority
  always_comb begin
    jog_cap = (control_method_i == cirm_pkg::CTRL_OLV2) ?
      cirm_pkg::JOG_OLV2_MAX : cirm_pkg::JOG_MAX; // [R16]
    if (max_output_frequency_setting_i < jog_cap) begin
      jog_cap = max_output_frequency_setting_i; // [R16]
    end
    jog_lim = (jog_frequency_setting_i > jog_cap) ? jog_cap :
      jog_frequency_setting_i; // [R15]
  end

  assign fwd_jog = act[cirm_pkg::FN_FWD_JOG];
  assign rev_jog = act[cirm_pkg::FN_REV_JOG];
  assign jog_any = fwd_jog || rev_jog;
  assign both_jog = fwd_jog && rev_jog;

  always_comb begin
    if (conflict_latched || conflict_expired) begin
      next_freq = '0; // [R18]
      next_run = 1'b0;
      next_reverse = 1'b0;
    end else if (jog_any) begin
      next_freq = jog_lim; // [R17]
      next_run = 1'b1; // [R14]
      next_reverse = rev_jog && !fwd_jog; // [R14]
    end else if (option_selected_o) begin
      next_freq = trimmed;
      next_run = option_run_i; // [R12]
      next_reverse = option_reverse_i;
    end else begin
      next_freq = trimmed;
      next_run = run_sync[0] &&
        run_source_select_i == cirm_pkg::RUN_SRC_TERMINAL; // [R12]
      next_reverse = run_sync[1];
    end
  end

  // ==========================================================
  // Jog conflict stop, held until both jogs released
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      conflict_latched <= 1'b0;
    end else if (conflict_expired) begin
      conflict_latched <= 1'b1; // [R18]
    end else if (!jog_any) begin
      conflict_latched <= 1'b0;
    end
  end

  assign next_error =
    (asg[cirm_pkg::FN_TRIM_UP] ^ asg[cirm_pkg::FN_TRIM_DN]) ||
    (asg[cirm_pkg::FN_SAMPLE_HOLD] && (asg[cirm_pkg::FN_RAMP_HOLD] ||
    asg[cirm_pkg::FN_UP] || asg[cirm_pkg::FN_DOWN] ||
    asg[cirm_pkg::FN_TRIM_UP] || asg[cirm_pkg::FN_TRIM_DN])); // [R06] [R08]

  // ==========================================================
  // Output registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      frequency_reference_o <= '0;
      run_command_o <= 1'b0;
      run_reverse_o <= 1'b0;
      jog_active_o <= 1'b0;
      stop_request_o <= 1'b0;
      stop_method_o <= '0;
      invalid_input_selection_error_o <= 1'b0;
    end else begin
      frequency_reference_o <= next_freq;
      run_command_o <= next_run;
      run_reverse_o <= next_reverse;
      jog_active_o <= jog_any && !conflict_latched && !conflict_expired;
      stop_request_o <= conflict_latched || conflict_expired; // [R18]
      stop_method_o <= stop_method_select_i; // [R18]
      invalid_input_selection_error_o <= next_error; // [R06] [R08]
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_trim_none;
    act[cirm_pkg::FN_TRIM_UP] == act[cirm_pkg::FN_TRIM_DN] && !jog_any &&
      !conflict_latched && !conflict_expired
      |=> frequency_reference_o == $past(base_ref);
  endproperty
  a_trim_none: assert property (p_trim_none) // [R03]
    else $error("trim changed reference with equal trim inputs");

  property p_trim_floor;
    trim_en && act[cirm_pkg::FN_TRIM_DN] && !act[cirm_pkg::FN_TRIM_UP] &&
      base_ref < trim_amt && !jog_any && !stop_request_o && !conflict_expired
      |=> frequency_reference_o == '0;
  endproperty
  a_trim_floor: assert property (p_trim_floor) // [R05]
    else $error("negative trim not clamped to zero");

  property p_trim_gate;
    (!from_analog || base_ref == '0) && !jog_any && !conflict_latched &&
      !conflict_expired |=> frequency_reference_o == $past(base_ref);
  endproperty
  a_trim_gate: assert property (p_trim_gate) // [R04]
    else $error("trim enabled for non-analog reference");

  property p_pair_error;
    asg[cirm_pkg::FN_TRIM_UP] != asg[cirm_pkg::FN_TRIM_DN]
      |=> invalid_input_selection_error_o;
  endproperty
  a_pair_error: assert property (p_pair_error) // [R06]
    else $error("single trim function not flagged");

  property p_hold_error;
    asg[cirm_pkg::FN_SAMPLE_HOLD] && (asg[cirm_pkg::FN_RAMP_HOLD] ||
      asg[cirm_pkg::FN_UP] || asg[cirm_pkg::FN_DOWN])
      |=> invalid_input_selection_error_o;
  endproperty
  a_hold_error: assert property (p_hold_error) // [R08]
    else $error("sample-hold conflict not flagged");

  property p_hold_capture;
    sample_fire |=> hold_valid_o && held_ref == $past(analog_reference_i);
  endproperty
  a_hold_capture: assert property (p_hold_capture) // [R07]
    else $error("sample not captured");

  property p_hold_cause;
    $changed(held_ref) |-> $past(act[cirm_pkg::FN_SAMPLE_HOLD]);
  endproperty
  a_hold_cause: assert property (p_hold_cause) // [R09]
    else $error("held value changed without sample input");

  property p_src_frozen;
    drive_running_i |=> $stable(option_selected_o);
  endproperty
  a_src_frozen: assert property (p_src_frozen) // [R11]
    else $error("source switched while running");

  property p_option_run;
    option_selected_o && !jog_any && !stop_request_o && !conflict_expired
      |=> run_command_o == $past(option_run_i);
  endproperty
  a_option_run: assert property (p_option_run) // [R12]
    else $error("option card run not followed");

  property p_jog;
    jog_any && !both_jog && !conflict_latched && !conflict_expired
      |=> run_command_o && jog_active_o &&
      frequency_reference_o == $past(jog_lim);
  endproperty
  a_jog: assert property (p_jog) // [R14] [R17]
    else $error("jog did not override reference");

  property p_jog_limit;
    jog_lim <= max_output_frequency_setting_i &&
      (control_method_i != cirm_pkg::CTRL_OLV2 ||
      jog_lim <= cirm_pkg::JOG_OLV2_MAX);
  endproperty
  a_jog_limit: assert property (p_jog_limit) // [R16]
    else $error("jog frequency above limit");

  property p_conflict;
    $rose(stop_request_o) |-> $past(both_jog) && !run_command_o;
  endproperty
  a_conflict: assert property (p_conflict) // [R18]
    else $error("stop without jog conflict");

  c_hold: cover property (sample_fire ##1 hold_valid_o);
  c_conflict: cover property ($rose(stop_request_o));
  c_trim_up: cover property (trim_en && act[cirm_pkg::FN_TRIM_UP] &&
    !act[cirm_pkg::FN_TRIM_DN]);
  c_option: cover property ($rose(option_selected_o));
endmodule
`default_nettype wire

// >>> shared/cirm_pkg.sv
// Constants for the contact-input reference modifier.
// Assumes a single 40 MHz core clock; frequencies are in 0.01 Hz units.
package cirm_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_INPUTS = 10;
  localparam int CODE_W = 8;
  localparam int FREQ_W = 16;
  localparam int PCT_W = 7;
  localparam int SRC_W = 4;
  localparam int CTRL_W = 3;
  localparam int STOP_W = 2;
  localparam int TIMER_W = 32;
  localparam int PROD_W = FREQ_W + PCT_W;

  // ==========================================================
  // Input function codes
  localparam logic [CODE_W-1:0] CODE_OPT_SEL = 8'h02;
  localparam logic [CODE_W-1:0] CODE_RAMP_HOLD = 8'h0a;
  localparam logic [CODE_W-1:0] CODE_UP = 8'h10;
  localparam logic [CODE_W-1:0] CODE_DOWN = 8'h11;
  localparam logic [CODE_W-1:0] CODE_FWD_JOG = 8'h12;
  localparam logic [CODE_W-1:0] CODE_REV_JOG = 8'h13;
  localparam logic [CODE_W-1:0] CODE_TRIM_UP = 8'h1c;
  localparam logic [CODE_W-1:0] CODE_TRIM_DN = 8'h1d;
  localparam logic [CODE_W-1:0] CODE_SAMPLE_HOLD = 8'h1e;

  // Function indices in the flag vectors
  localparam int FN_OPT_SEL = 0;
  localparam int FN_RAMP_HOLD = 1;
  localparam int FN_UP = 2;
  localparam int FN_DOWN = 3;
  localparam int FN_FWD_JOG = 4;
  localparam int FN_REV_JOG = 5;
  localparam int FN_TRIM_UP = 6;
  localparam int FN_TRIM_DN = 7;
  localparam int FN_SAMPLE_HOLD = 8;
  localparam int NUM_FUNCS = 9;

  localparam logic [NUM_FUNCS-1:0][CODE_W-1:0] FUNC_CODES = {
    CODE_SAMPLE_HOLD, CODE_TRIM_DN, CODE_TRIM_UP, CODE_REV_JOG,
    CODE_FWD_JOG, CODE_DOWN, CODE_UP, CODE_RAMP_HOLD, CODE_OPT_SEL
  };

  // ==========================================================
  // Settings
  localparam logic [SRC_W-1:0] REF_SRC_TERMINAL = 4'h1;
  localparam logic [SRC_W-1:0] RUN_SRC_TERMINAL = 4'h1;
  localparam logic [CTRL_W-1:0] CTRL_OLV2 = 3'h4;
  localparam logic [PCT_W-1:0] TRIM_PCT_MAX = 7'h64;
  localparam logic [PCT_W-1:0] TRIM_PCT_DEFAULT = 7'h0a;
  localparam logic [PROD_W-1:0] PCT_DIVISOR = 23'h000064;
  localparam logic [FREQ_W-1:0] JOG_MAX = 16'h9c40;
  localparam logic [FREQ_W-1:0] JOG_OLV2_MAX = 16'h19c8;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int SAMPLE_DELAY_MS = 100;
  localparam int CONFLICT_MS = 500;
  localparam int SAMPLE_DELAY_CYCLES = (CLK_HZ / 1000) * SAMPLE_DELAY_MS;
  localparam int CONFLICT_CYCLES = (CLK_HZ / 1000) * CONFLICT_MS;

endpackage

// >>> shared/func_flags_if.sv
// Per-function assignment and activity flags between decoder and core.
// Assumes both ends share the core clock.
`timescale 1ns/100ps
`default_nettype none
interface func_flags_if #(parameter int NUM_FUNCS = 9);
  logic [NUM_FUNCS-1:0] assigned;
  logic [NUM_FUNCS-1:0] active;
  modport source(output assigned, output active);
  modport sink(input assigned, input active);
endinterface
`default_nettype wire

// >>> rtl/input_decode.sv
// Contact pin synchroniser and function-code decoder.
// Assumes pins are asynchronous; selections are static settings.
`timescale 1ns/100ps
`default_nettype none
module input_decode (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Contact pins and function selections
  input wire logic [cirm_pkg::NUM_INPUTS-1:0] contact_pin_i,
  input wire logic [cirm_pkg::NUM_INPUTS-1:0][cirm_pkg::CODE_W-1:0]
    function_select_i,
  // Decoded flags
  func_flags_if.source flags
);
  logic [cirm_pkg::NUM_INPUTS-1:0] pin_meta;
  logic [cirm_pkg::NUM_INPUTS-1:0] pin_sync;
  logic [cirm_pkg::NUM_FUNCS-1:0] asg_c;
  logic [cirm_pkg::NUM_FUNCS-1:0] act_c;

  // ==========================================================
  // Two-stage pin synchroniser
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= contact_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // Any input may carry any function
  for (genvar f = 0; f < cirm_pkg::NUM_FUNCS; f++) begin : g_func
    logic [cirm_pkg::NUM_INPUTS-1:0] hit;
    for (genvar i = 0; i < cirm_pkg::NUM_INPUTS; i++) begin : g_in
      assign hit[i] = function_select_i[i] == cirm_pkg::FUNC_CODES[f]; // [R01]
    end
    assign asg_c[f] = |hit;
    assign act_c[f] = |(hit & pin_sync);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      flags.assigned <= '0;
      flags.active <= '0;
    end else begin
      flags.assigned <= asg_c;
      flags.active <= act_c;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/hold_timer.sv
// Qualification timer: counts while a condition holds.
// Assumes the condition is a same-clock level.
`timescale 1ns/100ps
`default_nettype none
module hold_timer #(
  parameter int unsigned CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Condition and results
  input wire logic cond_i,
  output logic expired_o,
  output logic fire_o
);
  localparam logic [cirm_pkg::TIMER_W-1:0] LAST = CYCLES - 1;
  localparam logic [cirm_pkg::TIMER_W-1:0] FULL = CYCLES;

  logic [cirm_pkg::TIMER_W-1:0] count;

  if (CYCLES < 1) begin : g_chk
    $error("hold_timer CYCLES must be at least one");
  end

  // Restarts whenever the condition drops
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !cond_i) begin
      count <= '0; // [R19]
    end else if (count != FULL) begin
      count <= count + 32'h1;
    end
  end

  assign expired_o = count == FULL;
  assign fire_o = cond_i && count == LAST;
endmodule
`default_nettype wire

// >>> test/contact_controller_model.sv
// Far-side model: external controller on the contact pins plus option card.
// Assumes the bench calls its tasks; pin changes land just after an edge.
`timescale 1ns/100ps
`default_nettype none
module contact_controller_model (
  // Clock
  input wire logic core_clk_i,
  // Contact and terminal pins
  output logic [cirm_pkg::NUM_INPUTS-1:0] contact_pin_o,
  output logic terminal_run_pin_o,
  output logic terminal_reverse_pin_o,
  // Source settings of the configuring party
  output logic [cirm_pkg::SRC_W-1:0] reference_source_select_o,
  output logic [cirm_pkg::SRC_W-1:0] run_source_select_o,
  // Option card
  output logic [cirm_pkg::FREQ_W-1:0] option_reference_o,
  output logic option_run_o,
  output logic option_reverse_o
);
  initial begin
    contact_pin_o = '0;
    terminal_run_pin_o = 1'b0;
    terminal_reverse_pin_o = 1'b0;
    reference_source_select_o = cirm_pkg::REF_SRC_TERMINAL;
    run_source_select_o = cirm_pkg::RUN_SRC_TERMINAL;
    option_reference_o = 16'h0abc;
    option_run_o = 1'b1;
    option_reverse_o = 1'b1;
  end

  // ==========================================================
  // Contact drive
  task automatic set_pin(input int idx, input logic val);
    @(posedge core_clk_i);
    #2;
    contact_pin_o[idx] = val;
  endtask

  // Press a contact for a number of cycles, then release
  task automatic press(input int idx, input int cycles);
    set_pin(idx, 1'b1);
    repeat (cycles) @(posedge core_clk_i);
    #2;
    contact_pin_o[idx] = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/contact_input_reference_modifier_tb_top.sv
// Bench for the contact-input reference modifier.
// Assumes shortened delays: 20 cycles sample, 50 cycles jog conflict.
`timescale 1ns/100ps
`default_nettype none
module contact_input_reference_modifier_tb_top;
  logic clk, rst, run;
  logic [9:0][7:0] sel;
  logic [6:0] lvl;
  logic [15:0] jog, mx, ana, f_o, oref;
  logic [1:0] stp, sm_o;
  logic [2:0] ctrl;
  logic [3:0] rsrc, qsrc;
  logic [9:0] pins;
  logic trun, trev, orun, orev, rc_o, rv_o, jg_o, os_o, hv_o, sr_o, er_o;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  contact_controller_model model (.core_clk_i(clk), .contact_pin_o(pins),
    .terminal_run_pin_o(trun), .terminal_reverse_pin_o(trev),
    .reference_source_select_o(rsrc), .run_source_select_o(qsrc),
    .option_reference_o(oref), .option_run_o(orun), .option_reverse_o(orev));

  contact_input_reference_modifier #(.SAMPLE_DELAY_CYCLES(20),
    .CONFLICT_CYCLES(50)) DUT (.core_clk_i(clk), .sys_rst_i(rst),
    .contact_pin_i(pins), .input_function_select_i(sel),
    .terminal_run_pin_i(trun), .terminal_reverse_pin_i(trev),
    .trim_level_setting_i(lvl), .jog_frequency_setting_i(jog),
    .max_output_frequency_setting_i(mx), .reference_source_select_i(rsrc),
    .run_source_select_i(qsrc), .stop_method_select_i(stp),
    .control_method_i(ctrl), .drive_running_i(run), .analog_reference_i(ana),
    .option_reference_i(oref), .option_run_i(orun), .option_reverse_i(orev),
    .frequency_reference_o(f_o), .run_command_o(rc_o), .run_reverse_o(rv_o),
    .jog_active_o(jg_o), .option_selected_o(os_o), .hold_valid_o(hv_o),
    .stop_request_o(sr_o), .stop_method_o(sm_o),
    .invalid_input_selection_error_o(er_o));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Common tasks
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    settle(4);
    rst = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_jog();
    sel = '0;
    sel[0] = cirm_pkg::CODE_FWD_JOG;
    sel[1] = cirm_pkg::CODE_REV_JOG;
    model.set_pin(0, 1'b1);
    settle(6);
    check("fwd run", 16'h1, rc_o);
    check("fwd ref", 16'h05dc, f_o);
    check("fwd dir", 16'h0, rv_o);
    model.set_pin(0, 1'b0);
    model.set_pin(1, 1'b1);
    settle(6);
    check("rev dir", 16'h1, rv_o);
    check("rev active", 16'h1, jg_o);
    ctrl = cirm_pkg::CTRL_OLV2;
    jog = 16'h1f40;
    settle(4);
    check("olv2 jog", cirm_pkg::JOG_OLV2_MAX, f_o);
    ctrl = 3'h0;
    jog = 16'h05dc;
    model.set_pin(1, 1'b0);
    settle(6);
    check("jog off", 16'h0, jg_o);
    $display("done jog");
  endtask

  task automatic t_conflict();
    model.set_pin(0, 1'b1);
    model.set_pin(1, 1'b1);
    settle(40);
    model.set_pin(1, 1'b0);
    model.set_pin(1, 1'b1);
    settle(40);
    check("early stop", 16'h0, sr_o);
    check("early dir", 16'h0, rv_o);
    settle(20);
    check("stop", 16'h1, sr_o);
    check("stop run", 16'h0, rc_o);
    check("stop method", 16'h2, sm_o);
    model.set_pin(0, 1'b0);
    model.set_pin(1, 1'b0);
    settle(6);
    check("stop clear", 16'h0, sr_o);
    $display("done conflict");
  endtask

  task automatic t_trim();
    logic [1:0] pp [6] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b10, 2'b01};
    logic [15:0] aa [6] = '{16'h0bb8, 16'h0bb8, 16'h0bb8, 16'h0bb8,
                            16'h01f4, 16'h0000};
    logic [15:0] ee [6] = '{16'h0fa0, 16'h07d0, 16'h0bb8, 16'h0bb8,
                            16'h0000, 16'h0000};
    sel = '0;
    sel[2] = cirm_pkg::CODE_TRIM_UP;
    sel[3] = cirm_pkg::CODE_TRIM_DN;
    // Running: a new level must not take effect
    run = 1'b1;
    lvl = 7'h14;
    for (int i = 0; i < 6; i++) begin
      ana = aa[i];
      model.set_pin(2, pp[i][0]);
      model.set_pin(3, pp[i][1]);
      settle(6);
      check("trim ref", ee[i], f_o);
    end
    run = 1'b0;
    lvl = 7'h0a;
    check("pair ok", 16'h0, er_o);
    sel[3] = 8'h00;
    settle(6);
    check("lone trim", 16'h1, er_o);
    model.set_pin(2, 1'b0);
    $display("done trim");
  endtask

  task automatic t_config();
    logic [7:0] cc [3] = '{cirm_pkg::CODE_RAMP_HOLD, cirm_pkg::CODE_UP,
                           cirm_pkg::CODE_DOWN};
    sel = '0;
    sel[4] = cirm_pkg::CODE_SAMPLE_HOLD;
    settle(6);
    check("hold alone", 16'h0, er_o);
    for (int i = 0; i < 3; i++) begin
      sel[6] = cc[i];
      settle(6);
      check("hold mix", 16'h1, er_o);
    end
    sel[6] = 8'h00;
    $display("done config");
  endtask

  task automatic t_hold();
    ana = 16'h0640;
    settle(6);
    model.press(4, 10);
    settle(30);
    check("short hold", 16'h0, hv_o);
    model.press(4, 40);
    check("hold valid", 16'h1, hv_o);
    ana = 16'h0320;
    settle(6);
    check("held ref", 16'h0640, f_o);
    do_reset();
    check("reset ref", 16'h0, f_o);
    settle(6);
    check("hold lost", 16'h0, hv_o);
    check("live ref", 16'h0320, f_o);
    $display("done hold");
  endtask

  task automatic t_option();
    sel = '0;
    sel[5] = cirm_pkg::CODE_OPT_SEL;
    sel[2] = cirm_pkg::CODE_TRIM_UP;
    sel[3] = cirm_pkg::CODE_TRIM_DN;
    run = 1'b1;
    model.set_pin(2, 1'b1);
    model.set_pin(5, 1'b1);
    settle(6);
    check("no switch", 16'h0, os_o);
    run = 1'b0;
    settle(6);
    check("opt sel", 16'h1, os_o);
    check("opt ref", 16'h0abc, f_o);
    check("opt run", 16'h1, rc_o);
    check("opt dir", 16'h1, rv_o);
    model.set_pin(5, 1'b0);
    settle(6);
    check("term run", 16'h0, rc_o);
    check("term ref", 16'h0708, f_o);
    $display("done option");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      $display("ERROR timeout expected done seen hang");
      tally_and_finish();
    end
  end

  initial begin
    rst = 1'b1;
    run = 1'b0;
    sel = '0;
    lvl = 7'h0a;
    jog = 16'h05dc;
    mx = 16'h2710;
    ana = 16'h0fa0;
    stp = 2'h2;
    ctrl = 3'h0;
    do_reset();
    t_jog();
    t_conflict();
    t_trim();
    t_config();
    t_hold();
    t_option();
    tally_and_finish();
  end
endmodule
`default_nettype wire
